// ---- rtl/fps_regs.svh ----
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

`define SYS_CLK_MHZ 100
// Plateau sample delay after the flyback phase begins
`define OVP_SAMPLE_NS 2500
`define OVP_SAMPLE_CYC ((`OVP_SAMPLE_NS * `SYS_CLK_MHZ + 999) / 1000)
// Successive over-voltage samples that qualify a true fault
`define OVP_QUALIFY_CNT 3
`define SOFT_START_MS 4
`define SOFT_START_CYC (`SOFT_START_MS * `SYS_CLK_MHZ * 1000)
// Debounce is counted in switching cycles at a nominal period
`define FAULT_DEBOUNCE_MS 75
`define NOM_PERIOD_NS 12500
`define FAULT_DEBOUNCE_CYC (`FAULT_DEBOUNCE_MS * 1000000 / `NOM_PERIOD_NS)
`define ON_TIME_CYC 500
`define DEAD_TIME_CYC 4
`define CS_LIMIT_MAX 8'hff

`endif

// ---- rtl/fps_pkg.sv ----
package fps_pkg;

   // Comparator outputs from the analog front end
   typedef struct packed {
      logic fb_below_burst;
      logic aux_plateau_high;
      logic demag_valley;
      logic supply_turn_on;
      logic supply_undervoltage_off_level;
      logic supply_latch_high;
      logic supply_ovp;
      logic overload_fault;
      logic overcurrent_fault;
      logic overpower_fault;
      logic open_loop_fault;
      logic pin_floating;
   } pins_t;

   typedef enum logic [2:0] {
      ST_STARTUP = 3'h0,
      ST_SOFT    = 3'h1,
      ST_RUN     = 3'h3,
      ST_AUTO    = 3'h2,
      ST_LATCH   = 3'h6
   } seq_state_t;

   typedef struct packed {
      pins_t s1;
      pins_t s2;
      seq_state_t st;
      logic phase_on;
      logic sampled;
      logic [15:0] cyc;
      logic [15:0] tmr;
      logic [1:0] ovp_cnt;
      logic [15:0] deb;
      logic gate_req;
      logic hs;
      logic ls;
      logic [3:0] dead;
      logic hv;
      logic [7:0] cs;
      logic latched;
      logic auto_rec;
   } seq_regs_t;

endpackage

// ---- rtl/flyback_protection_sequencer.sv ----
// How it works
// [R01] Feedback below burst level stops all switching
// [R02] Sample aux plateau 2.5us into flyback
// [R03] Three successive over-voltage samples latch fault
// [R04] A clean sample clears the over-voltage count
// [R05] Latched fault stops switching for good
// [R06] Latched: charge at 9V, stop at 12V
// [R07] Latch survives supply ramps until mains removed
// [R08] Supply over-voltage latches like output over-voltage
// [R09] Load faults must persist 75ms before tripping
// [R10] Auto-recovery stops, resets at 9V off level
// [R11] Restart runs normally or repeats while faulted
// [R12] Floating pin trips auto-recovery immediately
// [R13] High and low gate switches never both on
// [R14] Start switching when supply reaches 15V
// [R15] Each restart begins with 4ms soft start
// [R16] Debounce counts switching periods, not time
// [R17] Only power-on reset clears the latch
// [R18] Count advances once per cycle, one sample
`timescale 1ns/1ps
`include "fps_regs.svh"

module flyback_protection_sequencer #(
   parameter int SS_CYC = `SOFT_START_CYC,
   parameter int DEBOUNCE_CYC = `FAULT_DEBOUNCE_CYC,
   parameter int ON_CYC = `ON_TIME_CYC,
   parameter int DEAD_CYC = `DEAD_TIME_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire fps_pkg::pins_t pins_i,
   output logic gate_high_o,
   output logic gate_low_o,
   output logic hv_charge_en_o,
   output logic [7:0] cs_limit_o,
   output logic fault_latched_o,
   output logic auto_recovery_o
);
   import fps_pkg::*;

   localparam int SAMPLE_CYC = `OVP_SAMPLE_CYC;
   localparam int SS_STEP_RAW = SS_CYC / 255;
   localparam int SS_STEP = (SS_STEP_RAW < 1) ? 1 : SS_STEP_RAW;
   localparam logic [15:0] SS_STEP_LAST = 16'(SS_STEP - 1);
   localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYC - 1);
   localparam logic [15:0] ON_LAST = 16'(ON_CYC - 1);
   localparam logic [15:0] DEB_LAST = 16'(DEBOUNCE_CYC - 1);
   localparam logic [3:0] DEAD_LOAD = 4'(DEAD_CYC);
   localparam logic [1:0] OVP_LAST = 2'(`OVP_QUALIFY_CNT - 1);

   seq_regs_t q;
   seq_regs_t d;
   logic active;
   logic may_switch;
   logic sample_now;
   logic load_fault;

   always_comb begin
      d = q;
      d.s1 = pins_i;
      d.s2 = q.s1;
      active = (q.st == ST_SOFT) || (q.st == ST_RUN);
      may_switch = active && !q.s2.fb_below_burst; // R01
      // Exactly one sample per flyback phase
      sample_now = active && !q.phase_on && !q.sampled &&
                   (q.cyc == SAMPLE_LAST); // R02 R18
      load_fault = q.s2.overload_fault || q.s2.overcurrent_fault ||
                   q.s2.overpower_fault || q.s2.open_loop_fault;

      // Switching cycle: fixed on time, then flyback until the valley
      if (q.cyc != 16'hffff) begin
         d.cyc = q.cyc + 16'h0001;
      end
      if (!active) begin
         d.phase_on = 1'b0;
         d.sampled = 1'b1;
         d.cyc = 16'h0000;
      end else if (q.phase_on) begin
         if (q.cyc == ON_LAST) begin
            d.phase_on = 1'b0;
            d.sampled = 1'b0;
            d.cyc = 16'h0000;
         end
      end else if (q.sampled && q.s2.demag_valley && may_switch) begin
         d.phase_on = 1'b1;
         d.cyc = 16'h0000;
         // Debounce advances once per switching period
         if (load_fault) begin
            d.deb = q.deb + 16'h0001; // R16
         end
      end
      if (sample_now) begin
         d.sampled = 1'b1;
         if (q.s2.aux_plateau_high) begin
            d.ovp_cnt = q.ovp_cnt + 2'h1; // R03
         end else begin
            d.ovp_cnt = 2'h0; // R04
         end
      end
      // Any gap in the fault restarts the debounce
      if (!load_fault) begin
         d.deb = 16'h0000; // R09
      end
      d.gate_req = may_switch && d.phase_on; // R01

      case (q.st)
         ST_STARTUP: begin
            d.hv = 1'b1;
            d.cs = 8'h00;
            d.tmr = 16'h0000;
            if (q.s2.supply_turn_on) begin
               d.st = ST_SOFT; // R14 R15
               d.hv = 1'b0;
            end
         end
         ST_SOFT: begin
            // Ramp the current limit one step at a time
            d.tmr = q.tmr + 16'h0001;
            if (q.tmr == SS_STEP_LAST) begin
               d.tmr = 16'h0000;
               d.cs = q.cs + 8'h01; // R15
               if (q.cs == (`CS_LIMIT_MAX - 8'h01)) begin
                  d.st = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            d.cs = `CS_LIMIT_MAX;
         end
         ST_AUTO: begin
            d.hv = 1'b0;
            if (q.s2.supply_undervoltage_off_level) begin
               d.st = ST_STARTUP; // R10 R11
               d.hv = 1'b1;
               d.ovp_cnt = 2'h0;
               d.deb = 16'h0000;
            end
         end
         ST_LATCH: begin
            // Supply hovers between the two levels; never leaves
            if (q.s2.supply_undervoltage_off_level) begin
               d.hv = 1'b1; // R06
            end else if (q.s2.supply_latch_high) begin
               d.hv = 1'b0; // R06
            end
         end
         default: begin
            d.st = ST_LATCH;
         end
      endcase

      // Latch faults take priority over auto-recovery ones
      if (q.st != ST_LATCH) begin
         if (q.s2.supply_ovp ||
             (sample_now && q.s2.aux_plateau_high &&
              q.ovp_cnt == OVP_LAST)) begin
            d.st = ST_LATCH; // R03 R05 R08
            d.hv = 1'b0;
            d.gate_req = 1'b0;
         end else if (q.st != ST_AUTO &&
                      (q.s2.pin_floating || // R12
                       (load_fault && q.deb >= DEB_LAST))) begin
            d.st = ST_AUTO; // R09 R12
            d.hv = 1'b0;
            d.gate_req = 1'b0;
         end
      end
      if (d.st == ST_LATCH || d.st == ST_AUTO) begin
         d.cs = 8'h00;
      end
      // Status pins come from flops so they never show a decode glitch
      d.latched = (d.st == ST_LATCH);
      d.auto_rec = (d.st == ST_AUTO);

      // Break before make with a dead time in between
      if (q.dead != 4'h0) begin
         d.dead = q.dead - 4'h1;
      end
      if (q.gate_req) begin
         if (q.ls) begin
            d.ls = 1'b0; // R13
            d.dead = DEAD_LOAD;
         end else if (q.dead == 4'h0) begin
            d.hs = 1'b1; // R13
         end
      end else begin
         if (q.hs) begin
            d.hs = 1'b0; // R13
            d.dead = DEAD_LOAD;
         end else if (q.dead == 4'h0) begin
            d.ls = 1'b1;
         end
      end
   end

   // Reset is the power-on reset: the only way out of the latch
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0; // R17
         q.st <= ST_STARTUP;
         q.sampled <= 1'b1;
         q.hv <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign gate_high_o = q.hs;
   assign gate_low_o = q.ls;
   assign hv_charge_en_o = q.hv;
   assign cs_limit_o = q.cs;
   assign fault_latched_o = q.latched;
   assign auto_recovery_o = q.auto_rec;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_ovp_last_hit;
      sample_now && q.s2.aux_plateau_high && q.ovp_cnt == OVP_LAST;
   endsequence

   sequence s_in_latch;
      q.st == ST_LATCH;
   endsequence

   chk_burst_gate: assert property ( // R01
      $rose(q.gate_req) |-> $past(!q.s2.fb_below_burst))
      else $error("switching started below burst level");

   chk_no_cross: assert property ( // R13
      !(gate_high_o && gate_low_o))
      else $error("both gate switches on");

   chk_ovp_trip: assert property ( // R03
      s_ovp_last_hit |=> s_in_latch ##0 fault_latched_o)
      else $error("third over-voltage sample did not latch");

   chk_ovp_clear: assert property ( // R04
      (sample_now && !q.s2.aux_plateau_high) |=> q.ovp_cnt == 2'h0)
      else $error("clean sample left count nonzero");

   chk_latch_hold: assert property ( // R07
      s_in_latch |=> s_in_latch [*2])
      else $error("latch released without power-on reset");

   chk_latch_hv: assert property ( // R06
      (s_in_latch and q.s2.supply_undervoltage_off_level) |=> hv_charge_en_o)
      else $error("latched charging not enabled at off level");

   chk_float_now: assert property ( // R12
      (q.s2.pin_floating && (active || q.st == ST_STARTUP) &&
       !q.s2.supply_ovp &&
       !(sample_now && q.s2.aux_plateau_high && q.ovp_cnt == OVP_LAST))
      |=> auto_recovery_o)
      else $error("floating pin did not trip at once");

   chk_auto_restart: assert property ( // R10
      (q.st == ST_AUTO && q.s2.supply_undervoltage_off_level && !q.s2.supply_ovp)
      |=> (q.st == ST_STARTUP && hv_charge_en_o))
      else $error("auto-recovery did not restart at off level");

   chk_stopped_quiet: assert property ( // R05
      (q.st == ST_LATCH || q.st == ST_AUTO) |=> !gate_high_o [*3])
      else $error("gate switched while protection active");

   chk_turn_on: assert property ( // R14
      (q.st == ST_STARTUP && q.s2.supply_turn_on && !q.s2.supply_ovp &&
       !q.s2.pin_floating) |=> (q.st == ST_SOFT && cs_limit_o == 8'h00))
      else $error("no soft start at turn-on level");

   sequence s_soft_done;
      q.st == ST_SOFT ##1 q.st == ST_RUN;
   endsequence

   chk_sample_delay: assert property ( // R02
      sample_now |-> ($past(q.phase_on, 250) && !$past(q.phase_on, 249)))
      else $error("plateau sample not 2.5us into flyback");

   chk_one_sample: assert property ( // R18
      sample_now |=> (!sample_now) [*8])
      else $error("second plateau sample in one cycle");

   chk_ovp_count: assert property ( // R03
      (sample_now && q.s2.aux_plateau_high && q.ovp_cnt != OVP_LAST)
      |=> q.ovp_cnt == $past(q.ovp_cnt) + 2'h1)
      else $error("high sample did not advance the count");

   chk_debounce_held: assert property ( // R09
      $rose(auto_recovery_o) |->
      ($past(q.s2.pin_floating) || $past(q.deb) >= DEB_LAST))
      else $error("load fault tripped before debounce ran out");

   chk_auto_stop: assert property ( // R10
      $rose(auto_recovery_o) |-> (!hv_charge_en_o && cs_limit_o == 8'h00))
      else $error("auto-recovery entry left charge or limit on");

   chk_vdd_latch: assert property ( // R08
      (q.s2.supply_ovp && q.st != ST_LATCH)
      |=> (fault_latched_o && !hv_charge_en_o))
      else $error("supply over-voltage did not latch");

   chk_latch_hv_off: assert property ( // R06
      (s_in_latch ##0 (!q.s2.supply_undervoltage_off_level && q.s2.supply_latch_high))
      |=> !hv_charge_en_o)
      else $error("latched charging not stopped at upper level");

   chk_burst_hold: assert property ( // R01
      q.s2.fb_below_burst |=> !$rose(q.phase_on))
      else $error("new cycle started below burst level");

   chk_soft_full: assert property ( // R15
      s_soft_done |-> ($past(cs_limit_o) == (`CS_LIMIT_MAX - 8'h01) &&
                       cs_limit_o == `CS_LIMIT_MAX))
      else $error("run entered before the soft-start ramp ended");

endmodule

// ---- tb/flyback_stage_model.sv ----
`timescale 1ns/1ps
module flyback_stage_model #(
   parameter int DEMAG_CYC = 300
) (
   input wire logic sys_clk_i,
   input wire logic gate_high_i,
   input wire logic plateau_high_i,
   input wire logic slow_i,
   output logic demag_valley_o,
   output logic aux_plateau_high_o
);
   int cnt = 0;
   logic fly = 1'b0;
   logic done;
   // A heavier load needs longer to empty the core, so the valley comes late
   always @(posedge sys_clk_i) begin
      if (gate_high_i) begin
         fly <= 1'b1;
         cnt <= 0;
      end else if (fly) begin
         cnt <= cnt + 1;
      end
   end
   assign done = cnt >= DEMAG_CYC + (slow_i ? 200 : 0);
   // With no stored energy the sense winding sits low, like a valley
   assign demag_valley_o = !gate_high_i && (!fly || done);
   assign aux_plateau_high_o = fly && !gate_high_i && !done && plateau_high_i;
endmodule

// ---- tb/flyback_protection_sequencer_bench.sv ----
`timescale 1ns/1ps
module flyback_protection_sequencer_bench;
   import fps_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   pins_t p = '0;
   pins_t pins;
   logic plat = 1'b0;
   logic slow = 1'b0;
   logic valley, aux, gh, gl, hv, lat, ar, seen;
   logic [7:0] cs;
   int errors = 0;
   int checks = 0;
   initial forever #5 sys_clk_i = ~sys_clk_i;
   always_comb begin
      pins = p;
      pins.demag_valley = valley;
      pins.aux_plateau_high = aux;
   end
   flyback_stage_model stage (.sys_clk_i(sys_clk_i), .gate_high_i(gh),
      .plateau_high_i(plat), .slow_i(slow), .demag_valley_o(valley),
      .aux_plateau_high_o(aux));
   flyback_protection_sequencer #(.SS_CYC(2550), .DEBOUNCE_CYC(4),
      .ON_CYC(20), .DEAD_CYC(4)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .pins_i(pins), .gate_high_o(gh), .gate_low_o(gl),
      .hv_charge_en_o(hv), .cs_limit_o(cs), .fault_latched_o(lat),
      .auto_recovery_o(ar));
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   localparam int W_GATE = 0;
   localparam int W_LATCH = 1;
   localparam int W_AUTO = 2;
   function automatic logic pick(input int w);
      case (w)
         W_GATE: return gh;
         W_LATCH: return lat;
         default: return ar;
      endcase
   endfunction
   task automatic wait_lv(input int w, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && pick(w) !== v; i++) step(1);
      chk("wait", v, pick(w));
      if (pick(w) !== v) wrap_up();
   endtask
   task automatic rises(input int n);
      repeat (n) begin
         wait_lv(W_GATE, 1'b0, 700);
         wait_lv(W_GATE, 1'b1, 700);
      end
   endtask
   task automatic quiet(input int n);
      seen = 1'b0;
      repeat (n) begin
         step(1);
         seen |= gh;
      end
      chk("gate_idle", 1'b0, seen);
   endtask
   task automatic restart();
      p.supply_turn_on = 1'b0;
      p.supply_undervoltage_off_level = 1'b1;
      step(5);
      p.supply_undervoltage_off_level = 1'b0;
      p.supply_turn_on = 1'b1;
   endtask
   task automatic boot();
      rst_i = 1'b1;
      p = '0;
      plat = 1'b0;
      step(10);
      rst_i = 1'b0;
      chk("latch_off", 1'b0, lat);
      chk("hv_on", 1'b1, hv);
      p.supply_turn_on = 1'b1;
      step(100);
      chk("cs_ramp", 1'b1, cs < 8'hff);
      wait_lv(W_GATE, 1'b1, 4000);
      step(2700);
      chk("cs_full", 1'b1, cs === 8'hff);
      chk("hv_off", 1'b0, hv);
      $display("done boot");
   endtask
   task automatic t_burst();
      slow = 1'b1;
      rises(1);
      p.fb_below_burst = 1'b1;
      wait_lv(W_GATE, 1'b0, 100);
      quiet(1500);
      p.fb_below_burst = 1'b0;
      wait_lv(W_GATE, 1'b1, 900);
      slow = 1'b0;
      $display("done burst");
   endtask
   task automatic t_ovp();
      rises(1);
      plat = 1'b1;
      rises(2);
      plat = 1'b0;
      rises(1);
      plat = 1'b1;
      rises(2);
      chk("no_latch", 1'b0, lat);
      wait_lv(W_LATCH, 1'b1, 700);
      quiet(20);
      p.supply_turn_on = 1'b0;
      chk("hv_latched", 1'b0, hv);
      p.supply_undervoltage_off_level = 1'b1;
      step(3);
      chk("hv_charge", 1'b1, hv);
      p.supply_undervoltage_off_level = 1'b0;
      p.supply_latch_high = 1'b1;
      step(3);
      chk("hv_stop", 1'b0, hv);
      p.supply_turn_on = 1'b1;
      quiet(800);
      chk("latch_held", 1'b1, lat);
      chk("low_hold", 1'b1, gl);
      $display("done ovp");
   endtask
   task automatic t_vdd();
      p.supply_ovp = 1'b1;
      step(2);
      chk("vdd_early", 1'b0, lat);
      step(1);
      chk("vdd_latch", 1'b1, lat);
      chk("vdd_hv", 1'b0, hv);
      $display("done vdd");
   endtask
   task automatic t_float();
      p.pin_floating = 1'b1;
      step(2);
      chk("float_early", 1'b0, ar);
      step(1);
      chk("float_trip", 1'b1, ar);
      p.supply_turn_on = 1'b0;
      p.supply_undervoltage_off_level = 1'b1;
      step(3);
      chk("auto_reset", 1'b0, ar);
      p.supply_undervoltage_off_level = 1'b0;
      p.supply_turn_on = 1'b1;
      wait_lv(W_AUTO, 1'b1, 50);
      p.pin_floating = 1'b0;
      restart();
      wait_lv(W_GATE, 1'b1, 4000);
      $display("done float");
   endtask
   task automatic set_load(input int k, input logic v);
      case (k)
         0: p.overload_fault = v;
         1: p.overcurrent_fault = v;
         2: p.overpower_fault = v;
         default: p.open_loop_fault = v;
      endcase
   endtask
   task automatic t_load();
      for (int k = 0; k < 4; k++) begin
         rises(1);
         set_load(k, 1'b1);
         rises(2);
         set_load(k, 1'b0);
         step(5);
         chk("short_fault", 1'b0, ar);
         set_load(k, 1'b1);
         wait_lv(W_AUTO, 1'b1, 2500);
         quiet(50);
         set_load(k, 1'b0);
         restart();
         wait_lv(W_GATE, 1'b1, 4000);
         chk("cs_restart", 1'b1, cs < 8'hff);
      end
      $display("done load");
   endtask
   always @(negedge sys_clk_i) if (!rst_i) chk("overlap", 1'b0, gh & gl);
   initial begin
      boot();
      t_burst();
      t_ovp();
      boot();
      t_vdd();
      boot();
      t_float();
      t_load();
      wrap_up();
   end
endmodule
